// file: rtl/spi_master_port.sv
// Single-channel SPI master with pin routing and two clock domains
//
// Notes on behaviour
// - Bit order setting 0 sends MSB first, 1 sends LSB first.
// - Mode 0..3 selects CPOL/CPHA as 00, 01, 10, 11.
// - Word length is 1 to 32 bits, same for transmit and receive.
// - Rate codes 1..7 give 5000 down to 78.125 kHz serial clock.
// - Routing 0 plain outputs, 1 first connector, 3 digital I/O socket.
// - Socket routing forces eight lines out, eight in; plain restores.
// - Received word is captured into an input register for reading.
// - Loading the transmit word only stages it; start begins shifting.
// - Start runs one full-duplex transfer, MOSI out and MISO in.
// - Live MISO level can be sampled any time, 0 low, 1 high.
// - Status reads 0 while a transfer runs, 1 once completed.
// - Wait request is answered once the transfer has ended, or at once if given in the same cycle as start.
`timescale 1ns/1ps
module spi_master_port
  import spi_master_pkg::*;
(
  // System clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Link clock for the serial engine
  input wire logic link_clk_i,
  // Configuration and routing
  input wire spi_master_pkg::spi_cfg_t cfg_i,
  input wire logic [1:0] route_i,
  input wire logic [spi_master_pkg::DIR_W-1:0] line_direction_setup_i,
  input wire logic [2:0] plain_out_i,
  // Commands
  input wire logic [spi_master_pkg::WORD_W-1:0] tx_word_i,
  input wire logic tx_load_i,
  input wire logic start_i,
  input wire logic wait_i,
  // Status and data
  output logic done_o,
  output logic wait_done_o,
  output logic [spi_master_pkg::WORD_W-1:0] rx_word_o,
  output logic miso_level_o,
  output logic [spi_master_pkg::DIR_W-1:0] dio_dir_o,
  // First connector pins
  output logic conn_sck_o,
  output logic conn_mosi_o,
  output logic conn_aux_o,
  input wire logic conn_miso_i,
  // Digital I/O socket pins
  output logic dio_sck_o,
  output logic dio_mosi_o,
  output logic dio_aux_o,
  input wire logic dio_miso_i
);

  import spi_master_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // System domain

  logic busy_r;
  logic start_tog_r;
  logic [WORD_W-1:0] tx_stage_r;
  logic [WORD_W-1:0] launch_tx_r;
  spi_cfg_t launch_cfg_r;
  logic done_s;
  logic done_q_r;
  logic wait_pend_r;
  logic [1:0] miso_sys_s;
  logic [WORD_W-1:0] rx_hold_r;
  logic done_tog_r;

  wire start_ok = start_i && !busy_r;
  wire done_ev = done_s ^ done_q_r;
  wire wait_any = wait_i || wait_pend_r;
  wire len_lo = cfg_i.word_len < LEN_MIN;
  wire len_hi = cfg_i.word_len > LEN_MAX;
  wire [LEN_W-1:0] len_clamp =
    len_lo ? LEN_MIN : (len_hi ? LEN_MAX : cfg_i.word_len);
  wire spi_cfg_t cfg_clamp = '{cfg_i.lsb_first, cfg_i.mode, len_clamp,
                               (cfg_i.rate == 3'h0) ? 3'h1 : cfg_i.rate};
  wire miso_sel_sys = (route_i == ROUTE_DIO) ? miso_sys_s[1] : miso_sys_s[0];
  wire [DIR_W-1:0] dir_sel =
    (route_i == ROUTE_DIO) ? DIR_FORCED : line_direction_setup_i;

  bit_sync #(.W(1)) u_done_sync (
    .clk_i(clock_i),
    .rst_i(rst_i),
    .d_i(done_tog_r),
    .q_o(done_s)
  );

  bit_sync #(.W(2)) u_miso_sys_sync (
    .clk_i(clock_i),
    .rst_i(rst_i),
    .d_i({dio_miso_i, conn_miso_i}),
    .q_o(miso_sys_s)
  );

  // Staging only; nothing moves on the link until start
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tx_stage_r <= '0;
    end else if (tx_load_i) begin
      tx_stage_r <= tx_word_i;
    end
  end

  // Launch words stay frozen while busy; the link reads them then
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      launch_tx_r <= '0;
      launch_cfg_r <= CFG_RST;
      start_tog_r <= 1'b0;
    end else if (start_ok) begin
      launch_tx_r <= tx_stage_r;
      launch_cfg_r <= cfg_clamp;
      start_tog_r <= ~start_tog_r;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      done_q_r <= 1'b0;
      done_o <= 1'b1;
    end else begin
      done_q_r <= done_s;
      busy_r <= start_ok || (busy_r && !done_ev);
      done_o <= !(start_ok || (busy_r && !done_ev));
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rx_word_o <= '0;
    end else if (done_ev) begin
      rx_word_o <= rx_hold_r;
    end
  end

  // A wait is held until the running transfer has ended
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wait_pend_r <= 1'b0;
      wait_done_o <= 1'b0;
    end else begin
      wait_pend_r <= wait_any && busy_r;
      wait_done_o <= wait_any && !busy_r;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      miso_level_o <= 1'b0;
      dio_dir_o <= DIR_RST;
    end else begin
      miso_level_o <= miso_sel_sys;
      dio_dir_o <= dir_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link domain

  link_state_t st_r;
  spi_cfg_t cfg_l_r;
  logic [HALF_W-1:0] half_r;
  logic [HALF_W-1:0] div_r;
  logic [6:0] edge_r;
  logic [WORD_W-1:0] tx_r;
  logic [WORD_W-1:0] rx_r;
  logic sck_r;
  logic mosi_r;
  logic start_s;
  logic start_q_r;
  logic [1:0] route_s;
  logic [2:0] plain_s;
  logic [1:0] miso_s;
  logic cpol_s;

  bit_sync #(.W(1)) u_start_sync (
    .clk_i(link_clk_i),
    .rst_i(rst_i),
    .d_i(start_tog_r),
    .q_o(start_s)
  );

  // Quasi-static settings; glitches on change are the host's concern
  bit_sync #(.W(6)) u_cfg_sync (
    .clk_i(link_clk_i),
    .rst_i(rst_i),
    .d_i({cfg_i.mode[1], route_i, plain_out_i}),
    .q_o({cpol_s, route_s, plain_s})
  );

  bit_sync #(.W(2)) u_miso_sync (
    .clk_i(link_clk_i),
    .rst_i(rst_i),
    .d_i({dio_miso_i, conn_miso_i}),
    .q_o(miso_s)
  );

  wire start_ev = start_s ^ start_q_r;
  wire miso_bit = (route_s == ROUTE_DIO) ? miso_s[1] : miso_s[0];
  wire cpha = cfg_l_r.mode[0];
  wire tick = div_r == half_r - 10'h001;
  wire sample = edge_r[0] == cpha;
  wire advance = (edge_r[0] != cpha) && (edge_r != 7'h00);
  wire [6:0] last_edge = {cfg_l_r.word_len, 1'b0} - 7'h01;
  wire [LEN_W-1:0] pad_l = LEN_MAX - launch_cfg_r.word_len;
  wire [LEN_W-1:0] pad_c = LEN_MAX - cfg_l_r.word_len;
  wire [WORD_W-1:0] tx_align =
    launch_cfg_r.lsb_first ? launch_tx_r : (launch_tx_r << pad_l);
  wire [WORD_W-1:0] rx_shift = cfg_l_r.lsb_first ?
    {miso_bit, rx_r[WORD_W-1:1]} : {rx_r[WORD_W-2:0], miso_bit};
  wire [WORD_W-1:0] tx_shift =
    cfg_l_r.lsb_first ? (tx_r >> 1) : (tx_r << 1);
  wire [WORD_W-1:0] rx_final =
    cfg_l_r.lsb_first ? (rx_r >> pad_c) : rx_r;

  logic [HALF_W-1:0] half_sel;
  always_comb begin
    unique case (launch_cfg_r.rate)
      3'h2: half_sel = HALF_2;
      3'h3: half_sel = HALF_3;
      3'h4: half_sel = HALF_4;
      3'h5: half_sel = HALF_5;
      3'h6: half_sel = HALF_6;
      3'h7: half_sel = HALF_7;
      default: half_sel = HALF_1;
    endcase
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_q_r <= 1'b0;
      div_r <= '0;
    end else begin
      start_q_r <= start_s;
      div_r <= (st_r == ST_IDLE || tick) ? '0 : div_r + 10'h001;
    end
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      cfg_l_r <= CFG_RST;
      half_r <= HALF_1;
      edge_r <= '0;
      tx_r <= '0;
      rx_r <= '0;
      sck_r <= 1'b0;
      mosi_r <= 1'b0;
      done_tog_r <= 1'b0;
      rx_hold_r <= '0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          sck_r <= cpol_s;
          if (start_ev) begin
            st_r <= ST_SHIFT;
            cfg_l_r <= launch_cfg_r;
            half_r <= half_sel;
            edge_r <= '0;
            tx_r <= tx_align;
            rx_r <= '0;
            sck_r <= launch_cfg_r.mode[1];
            mosi_r <= launch_cfg_r.lsb_first ? tx_align[0]
                                             : tx_align[WORD_W-1];
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            sck_r <= ~sck_r;
            edge_r <= edge_r + 7'h01;
            if (sample) begin
              rx_r <= rx_shift;
            end
            if (advance) begin
              tx_r <= tx_shift;
              mosi_r <= cfg_l_r.lsb_first ? tx_r[1]
                                          : tx_r[WORD_W-2];
            end
            if (edge_r == last_edge) begin
              st_r <= ST_TAIL;
            end
          end
        end
        ST_TAIL: begin
          if (tick) begin
            st_r <= ST_IDLE;
            rx_hold_r <= rx_final;
            done_tog_r <= ~done_tog_r;
          end
        end
      endcase
    end
  end

  // Pin routing, registered at the pins
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      conn_sck_o <= 1'b0;
      conn_mosi_o <= 1'b0;
      conn_aux_o <= 1'b0;
      dio_sck_o <= 1'b0;
      dio_mosi_o <= 1'b0;
      dio_aux_o <= 1'b0;
    end else begin
      conn_sck_o <= (route_s == ROUTE_CONN) ? sck_r : plain_s[0];
      conn_mosi_o <= (route_s == ROUTE_CONN) ? mosi_r : plain_s[1];
      conn_aux_o <= (route_s == ROUTE_CONN) ? 1'b0 : plain_s[2];
      dio_sck_o <= (route_s == ROUTE_DIO) ? sck_r : plain_s[0];
      dio_mosi_o <= (route_s == ROUTE_DIO) ? mosi_r : plain_s[1];
      dio_aux_o <= (route_s == ROUTE_DIO) ? 1'b0 : plain_s[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  start_stage_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $changed(start_tog_r) |-> $past(start_i) && !$past(busy_r))
    else $error("transfer launched without a start");

  status_busy_a: assert property (@(posedge clock_i) disable iff (rst_i)
    start_ok |=> !done_o throughout (busy_r [*2]))
    else $error("status not running after start");

  wait_answer_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wait_i && !busy_r |=> wait_done_o)
    else $error("wait not answered while idle");

  wait_early_a: assert property (@(posedge clock_i) disable iff (rst_i)
    wait_done_o |-> !$past(busy_r))
    else $error("wait answered during a transfer");

  dir_force_a: assert property (@(posedge clock_i) disable iff (rst_i)
    route_i == ROUTE_DIO |=> dio_dir_o == DIR_FORCED)
    else $error("socket directions not forced");

  dir_restore_a: assert property (@(posedge clock_i) disable iff (rst_i)
    route_i == ROUTE_PLAIN |=> dio_dir_o == $past(line_direction_setup_i))
    else $error("direction setup not restored");

  rx_upper_a: assert property (@(posedge clock_i) disable iff (rst_i)
    done_o && !busy_r |-> (rx_word_o >> launch_cfg_r.word_len) == '0)
    else $error("unused received bits not zero");

  edge_count_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    st_r == ST_TAIL |-> edge_r == {cfg_l_r.word_len, 1'b0})
    else $error("wrong number of clock edges");

  idle_clock_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    st_r == ST_IDLE && $past(st_r) == ST_IDLE |-> sck_r == $past(cpol_s))
    else $error("idle clock not at polarity");

  idle_mosi_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    st_r == ST_IDLE && $past(st_r) == ST_IDLE |-> $stable(mosi_r))
    else $error("data line moved while idle");

  half_period_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
    st_r == ST_SHIFT && $changed(sck_r) && $past(st_r) == ST_SHIFT
    |-> $past(div_r) == half_r - 10'h001)
    else $error("half period length wrong");

  start_cov_c: cover property (@(posedge clock_i) disable iff (rst_i)
    start_ok ##[1:1000] done_ev);
  lsb_cov_c: cover property (@(posedge link_clk_i) disable iff (rst_i)
    st_r == ST_TAIL && cfg_l_r.lsb_first);
  phase_cov_c: cover property (@(posedge link_clk_i) disable iff (rst_i)
    st_r == ST_TAIL && cfg_l_r.mode == 2'h3);
  wait_cov_c: cover property (@(posedge clock_i) disable iff (rst_i)
    wait_pend_r ##1 wait_done_o);

endmodule // spi_master_port

// file: inc/spi_master_pkg.sv
// Shared constants and types for the SPI master port
package spi_master_pkg;

  localparam int WORD_W = 32;
  localparam int LEN_W = 6;
  localparam int HALF_W = 10;
  localparam int DIR_W = 16;

  // Pin routing codes
  localparam logic [1:0] ROUTE_PLAIN = 2'h0;
  localparam logic [1:0] ROUTE_CONN = 2'h1;
  localparam logic [1:0] ROUTE_DIO = 2'h3;

  // Socket bank directions while routed to it: upper eight out, lower in
  localparam logic [DIR_W-1:0] DIR_FORCED = 16'hFF00;
  localparam logic [DIR_W-1:0] DIR_RST = 16'h0000;

  // Word length limits
  localparam logic [LEN_W-1:0] LEN_MIN = 6'h01;
  localparam logic [LEN_W-1:0] LEN_MAX = 6'h20;

  // Link clock and serial clock rates
  localparam int LINK_CLK_HZ = 83_333_333;
  localparam int RATE_1_HZ = 5_000_000;
  localparam int RATE_2_HZ = 2_500_000;
  localparam int RATE_3_HZ = 1_250_000;
  localparam int RATE_4_HZ = 620_000;
  localparam int RATE_5_HZ = 312_500;
  localparam int RATE_6_HZ = 156_250;
  localparam int RATE_7_HZ = 78_125;

  // Link cycles per half serial clock, rounded up so no rate is exceeded
  localparam logic [HALF_W-1:0] HALF_1 =
    HALF_W'((LINK_CLK_HZ + 2 * RATE_1_HZ - 1) / (2 * RATE_1_HZ));
  localparam logic [HALF_W-1:0] HALF_2 =
    HALF_W'((LINK_CLK_HZ + 2 * RATE_2_HZ - 1) / (2 * RATE_2_HZ));
  localparam logic [HALF_W-1:0] HALF_3 =
    HALF_W'((LINK_CLK_HZ + 2 * RATE_3_HZ - 1) / (2 * RATE_3_HZ));
  localparam logic [HALF_W-1:0] HALF_4 =
    HALF_W'((LINK_CLK_HZ + 2 * RATE_4_HZ - 1) / (2 * RATE_4_HZ));
  localparam logic [HALF_W-1:0] HALF_5 =
    HALF_W'((LINK_CLK_HZ + 2 * RATE_5_HZ - 1) / (2 * RATE_5_HZ));
  localparam logic [HALF_W-1:0] HALF_6 =
    HALF_W'((LINK_CLK_HZ + 2 * RATE_6_HZ - 1) / (2 * RATE_6_HZ));
  localparam logic [HALF_W-1:0] HALF_7 =
    HALF_W'((LINK_CLK_HZ + 2 * RATE_7_HZ - 1) / (2 * RATE_7_HZ));

  // Master configuration; mode[1] is polarity, mode[0] is phase
  typedef struct packed {
    logic lsb_first;
    logic [1:0] mode;
    logic [LEN_W-1:0] word_len;
    logic [2:0] rate;
  } spi_cfg_t;

  localparam spi_cfg_t CFG_RST = '{1'b0, 2'h0, 6'h01, 3'h1};

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_TAIL} link_state_t;

endpackage

// file: rtl/bit_sync.sv
// Two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  // Clock and reset of the receiving domain
  input wire logic clk_i,
  input wire logic rst_i,
  // Level in, synchronised level out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule // bit_sync

// file: verif/spi_slave_model.sv
// Behavioural SPI slave that answers the master on its serial pins
`timescale 1ns/1ps
module spi_slave_model
  import spi_master_pkg::*;
(
  // Serial pins and slave select
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic sel_i,
  // Frame setup and reply word
  input wire spi_master_pkg::spi_cfg_t cfg_i,
  input wire logic [spi_master_pkg::WORD_W-1:0] reply_i,
  // Data line and observations
  output logic miso_o,
  output logic [spi_master_pkg::WORD_W-1:0] got_o,
  output int edges_o,
  output int half_ns_o
);
  int idx;
  int k;
  realtime last_t;
  wire logic samp_rise = cfg_i.mode[1] == cfg_i.mode[0];

  function automatic int pos(input int i);
    return cfg_i.lsb_first ? i : int'(cfg_i.word_len) - 1 - i;
  endfunction

  initial begin
    miso_o = 1'b0;
    got_o = '0;
    edges_o = 0;
    half_ns_o = 0;
    idx = 0;
    k = 0;
    last_t = 0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase 0 presents the first bit as soon as the frame opens
  always @(posedge sel_i) begin
    idx = 0;
    k = 0;
    edges_o = 0;
    got_o = '0;
    if (!cfg_i.mode[0]) begin
      miso_o = reply_i[pos(0)];
      idx = 1;
    end
  end

  // A released line does not keep its last level
  always @(negedge sel_i) miso_o = ~miso_o;

  always @(sck_i) if (sel_i) begin
    edges_o = edges_o + 1;
    half_ns_o = int'($realtime - last_t);
    last_t = $realtime;
    if (sck_i == samp_rise) begin
      if (k < int'(cfg_i.word_len)) got_o[pos(k)] = mosi_i;
      k++;
    end else begin
      miso_o = idx < int'(cfg_i.word_len) ? reply_i[pos(idx)] : ~miso_o;
      idx++;
    end
  end
endmodule // spi_slave_model

// file: verif/test_spi_master_port.sv
// Self-checking bench for the SPI master port
`timescale 1ns/1ps
module test_spi_master_port;
  import spi_master_pkg::*;
  typedef struct packed {
    spi_cfg_t cfg;
    logic [WORD_W-1:0] tx;
    logic [WORD_W-1:0] reply;
    logic [WORD_W-1:0] exp_rx;
  } row_t;

  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic link_clk_i = 1'b0;
  spi_cfg_t cfg = CFG_RST;
  logic [1:0] route = ROUTE_CONN;
  logic [DIR_W-1:0] dsetup = 16'h00F0;
  logic [2:0] plain = 3'h5;
  logic [WORD_W-1:0] tx = '0;
  logic [WORD_W-1:0] reply = '0;
  logic tx_load = 1'b0, start = 1'b0, wait_r = 1'b0, sel = 1'b0;
  logic ovr_en = 1'b0, ovr_v = 1'b0;
  logic done, wait_done, lvl, c_sck, c_mosi, c_aux, d_sck, d_mosi, d_aux;
  logic smiso;
  logic [WORD_W-1:0] rx, got;
  logic [DIR_W-1:0] dio_dir;
  int edges, half_ns;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int hv [8] = '{0, HALF_1, HALF_2, HALF_3, HALF_4, HALF_5, HALF_6, HALF_7};
  wire logic miso = ovr_en ? ovr_v : smiso;
  wire logic sck = route == ROUTE_DIO ? d_sck : c_sck;
  wire logic mosi = route == ROUTE_DIO ? d_mosi : c_mosi;
  wire logic c_miso = route == ROUTE_DIO ? ~miso : miso;
  wire logic d_miso = route == ROUTE_DIO ? miso : ~miso;

  row_t rows [9] = '{
    '{'{1'h0, 2'h0, 6'h08, 3'h1}, 32'h000000A5, 32'h0000003C, 32'h0000003C},
    '{'{1'h1, 2'h1, 6'h08, 3'h1}, 32'h00000013, 32'h000000C5, 32'h000000C5},
    '{'{1'h0, 2'h2, 6'h20, 3'h1}, 32'h12345678, 32'hDEADBEEF, 32'hDEADBEEF},
    '{'{1'h1, 2'h3, 6'h11, 3'h2}, 32'h0001ABCD, 32'hFFFFFFFF, 32'h0001FFFF},
    '{'{1'h0, 2'h1, 6'h01, 3'h3}, 32'h00000001, 32'hFFFFFFFE, 32'h00000000},
    '{'{1'h1, 2'h0, 6'h02, 3'h4}, 32'h00000002, 32'h00000001, 32'h00000001},
    '{'{1'h0, 2'h2, 6'h02, 3'h5}, 32'h00000001, 32'h00000002, 32'h00000002},
    '{'{1'h0, 2'h3, 6'h02, 3'h6}, 32'h00000003, 32'h00000001, 32'h00000001},
    '{'{1'h1, 2'h0, 6'h02, 3'h7}, 32'h00000001, 32'h00000002, 32'h00000002}
  };

  initial forever #5 clock_i = ~clock_i;
  initial begin
    #3.7;
    forever #6 link_clk_i = ~link_clk_i;
  end

  spi_master_port dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
    .cfg_i(cfg), .route_i(route), .line_direction_setup_i(dsetup),
    .plain_out_i(plain), .tx_word_i(tx), .tx_load_i(tx_load),
    .start_i(start), .wait_i(wait_r), .done_o(done),
    .wait_done_o(wait_done), .rx_word_o(rx), .miso_level_o(lvl),
    .dio_dir_o(dio_dir), .conn_sck_o(c_sck), .conn_mosi_o(c_mosi),
    .conn_aux_o(c_aux), .conn_miso_i(c_miso), .dio_sck_o(d_sck),
    .dio_mosi_o(d_mosi), .dio_aux_o(d_aux), .dio_miso_i(d_miso)
  );

  spi_slave_model slave_u (
    .sck_i(sck), .mosi_i(mosi), .sel_i(sel), .cfg_i(cfg),
    .reply_i(reply), .miso_o(smiso), .got_o(got), .edges_o(edges),
    .half_ns_o(half_ns)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [WORD_W-1:0] got_v, exp_v);
    num_checks++;
    if (got_v !== exp_v) begin
      bad_count++;
      $display("[ERR] %0t got %08h exp %08h", $time, got_v, exp_v);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic xfer(input row_t r);
    int n;
    logic [WORD_W-1:0] m;
    m = 32'hFFFFFFFF >> (32 - int'(r.cfg.word_len));
    @(posedge clock_i);
    cfg <= r.cfg;
    reply <= r.reply;
    tx <= r.tx;
    tx_load <= 1'b1;
    @(posedge clock_i);
    tx_load <= 1'b0;
    repeat (6) @(posedge clock_i);
    sel <= 1'b1;
    repeat (8) @(posedge clock_i);
    chk(edges, 0);
    start <= 1'b1;
    @(posedge clock_i);
    start <= 1'b0;
    wait_r <= 1'b1;
    @(posedge clock_i);
    wait_r <= 1'b0;
    #1;
    chk({31'h0, done}, 32'h0);
    n = 0;
    while (wait_done !== 1'b1 && n < 20000) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk({31'h0, done}, 32'h1);
    chk(rx, r.exp_rx);
    chk(got, r.tx & m);
    chk(edges, 2 * r.cfg.word_len);
    chk(half_ns, hv[r.cfg.rate] * 12);
    chk({31'h0, sck}, {31'h0, r.cfg.mode[1]});
    @(posedge clock_i);
    sel <= 1'b0;
  endtask

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      finish_test;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock_i);
    chk({31'h0, done}, 32'h1);
    chk(rx, 32'h0);
    rst_i <= 1'b0;
    foreach (rows[i]) xfer(rows[i]);
    // Socket routing and the live data line
    @(posedge clock_i);
    route <= ROUTE_DIO;
    repeat (10) @(posedge clock_i);
    chk({16'h0, dio_dir}, {16'h0, DIR_FORCED});
    xfer(rows[2]);
    @(posedge clock_i);
    ovr_en <= 1'b1;
    ovr_v <= 1'b1;
    repeat (5) @(posedge clock_i);
    #1;
    chk({31'h0, lvl}, 32'h1);
    @(posedge clock_i);
    ovr_v <= 1'b0;
    repeat (5) @(posedge clock_i);
    #1;
    chk({31'h0, lvl}, 32'h0);
    // Wait request while idle
    @(posedge clock_i);
    wait_r <= 1'b1;
    @(posedge clock_i);
    wait_r <= 1'b0;
    #1;
    chk({31'h0, wait_done}, 32'h1);
    // Back to plain outputs
    @(posedge clock_i);
    route <= ROUTE_PLAIN;
    ovr_en <= 1'b0;
    repeat (10) @(posedge clock_i);
    chk({16'h0, dio_dir}, {16'h0, dsetup});
    chk({29'h0, c_aux, c_mosi, c_sck}, {29'h0, plain});
    chk({29'h0, d_aux, d_mosi, d_sck}, {29'h0, plain});
    // Reset again after traffic
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1;
    chk(rx, 32'h0);
    chk({31'h0, done}, 32'h1);
    @(posedge clock_i);
    rst_i <= 1'b0;
    finish_test;
  end
endmodule // test_spi_master_port
